/* File: tb/prog_model.sv */
/*
  Programmer model: drives strobe, shift clock, serial data and guard.
  Assumes the port settles its serial output within 500 ns of an edge.
*/
`timescale 1ns/1ps
`default_nettype none

module prog_model (
  // Pins driven toward the port
  output logic o_sck,
  output logic o_strobe,
  output logic o_sdi,
  output logic o_guard,
  // Serial response and handshake from the port
  input wire logic i_sdo
);
  // Quiet pins, clock stands still outside frames
  initial begin
    o_sck = 1'b0;
    o_strobe = 1'b0;
    o_sdi = 1'b0;
    o_guard = 1'b1;
  end

  // One shift clock pulse at the 30 ns link rate
  task automatic pulse();
    #15 o_sck = 1'b1;
    #15 o_sck = 1'b0;
  endtask : pulse

  // Raw bits MSB first, data invalid again afterwards
  task automatic shift_raw(input logic [12:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      o_sdi = v[k];
      pulse();
    end
    o_sdi = ~o_sdi;
  endtask : shift_raw

  // Whole command cycle: shift, launch, busy sample, wait for release
  task automatic frame(input logic [31:0] cmd, output logic [31:0] resp,
                       output logic busy, output logic done);
    o_strobe = 1'b1;
    for (int k = 31; k >= 0; k--) begin
      o_sdi = cmd[k];
      #15 o_sck = 1'b1;
      #500 resp[k] = i_sdo;
      #15 o_sck = 1'b0;
    end
    o_sdi = ~o_sdi;
    o_strobe = 1'b0;
    #500 pulse();
    #15 o_sck = 1'b1;
    #1 busy = i_sdo;
    #14 o_sck = 1'b0;
    done = 1'b0;
    // Bounded wait for the handshake to return high
    for (int i = 0; i < 200 && done !== 1'b1; i++) begin
      #100 done = i_sdo;
    end
  endtask : frame
endmodule : prog_model

`default_nettype wire

/* File: tb/serial_program_port_tb.sv */
/*
  Bench for the serial programming port: key entry, write, read,
  guard block, external reset and normal run without key.
  Assumes the design and prog_model are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_program_port_params.svh"

module serial_program_port_tb;
  import serial_program_port_pkg::*;
  logic mclk, rst, ext_n, sck, strobe, sdi, guard, sdo;
  logic mem_req, mem_ack, prog_mode, run, ready, busy, done, seen_rdy;
  mem_req_t mem, seen_mem;
  logic [31:0] resp;
  logic [2:0] mcnt;
  int n_mismatch, total_checks, n_launch, i;

  serial_program_port #(.RESET_CYCLES(50)) dut (
    .i_mclk(mclk), .i_rst(rst), .i_ext_reset_n(ext_n),
    .i_shift_clock_pin(sck), .i_strobe_pin(strobe), .i_cmd_in_pin(sdi),
    .i_prog_guard_pin(guard), .o_resp_out_pin(sdo), .o_mem(mem),
    .o_mem_req(mem_req), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem.addr[7:0] ^ 8'h5a), .o_prog_mode(prog_mode),
    .o_run(run), .o_ready(ready));

  prog_model pm (.o_sck(sck), .o_strobe(strobe), .o_sdi(sdi),
    .o_guard(guard), .i_sdo(sdo));

  // 10 MHz main clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Memory stand-in: one-cycle ack, captures request at launch
  initial begin
    mcnt = 3'h0;
    mem_ack = 1'b0;
    n_launch = 0;
  end
  always @(negedge mclk) begin
    mcnt <= mem_req ? mcnt + 3'h1 : 3'h0;
    mem_ack <= mem_req && (mcnt == 3'h2);
    if (mem_req && mcnt == 3'h0) begin
      seen_mem <= mem;
      seen_rdy <= ready;
      n_launch <= n_launch + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // Command cycle; a stuck handshake ends the run
  task automatic run_frame(input logic [31:0] cmd);
    pm.frame(cmd, resp, busy, done);
    if (done !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
  endtask : run_frame

  // Power-on reset with link edges, then the reset sequence
  task automatic do_reset(input logic with_key);
    @(negedge mclk) rst = 1'b1;
    pm.shift_raw(13'h0, 4);
    repeat (16) @(negedge mclk);
    check({sdo, prog_mode, run, ready, mem_req}, 32'h10);
    rst = 1'b0;
    if (with_key)
      pm.shift_raw({3'h0, `KEY_VALUE}, 13);
    for (i = 0; i < 200 && !(prog_mode === 1'b1 || run === 1'b1); i++)
      @(negedge mclk);
    if (i == 200) begin
      n_mismatch++;
      summarize();
    end
  endtask : do_reset

  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    ext_n = 1'b1;
    do_reset(1'b1);
    check({prog_mode, run}, 32'h2);
    $display("test key entry done");
    run_frame(32'h200123a5);
    check(busy, 32'h0);
    check(32'(seen_mem), 32'(mem_req_t'{1'b1, 1'b0, 1'b1, 11'h123, 8'ha5}));
    check({seen_rdy, ready}, 32'h1);
    $display("test write done");
    run_frame(32'h11045600);
    check(resp[18:0], 32'h123a5);
    check(32'(seen_mem), 32'(mem_req_t'{1'b0, 1'b1, 1'b0, 11'h456, 8'h00}));
    // Guard low: the frame shifts but nothing is launched
    @(negedge mclk) pm.o_guard = 1'b0;
    run_frame(32'h20000000);
    check(resp[18:0], 32'h4560c);
    check(busy, 32'h1);
    check(n_launch, 32'h2);
    @(negedge mclk) pm.o_guard = 1'b1;
    $display("test read and guard done");
    @(negedge mclk) ext_n = 1'b0;
    repeat (5) @(negedge mclk);
    ext_n = 1'b1;
    repeat (80) @(negedge mclk);
    check(prog_mode, 32'h1);
    $display("test external reset done");
    do_reset(1'b0);
    check({prog_mode, run}, 32'h1);
    run_frame(32'h200123a5);
    check(busy, 32'h1);
    check(n_launch, 32'h2);
    $display("test no key done");
    summarize();
  end
endmodule : serial_program_port_tb

`default_nettype wire

/* File: verilog/serial_program_port.sv */
/*
  Serial in-circuit programming port: entry key capture during the
  reset sequence, 32-bit command/response shifting on the shift clock,
  busy handshake on the serial output and memory access on the main clock.
  Assumes the EEPROM arrays answer on i_mclk with a one-cycle ack, and
  that the programmer keeps to the shift and handshake timing.
*/
// Summary of operation
// - Key sent MSB first, taken on rising edge
// - Last ten bits matching key set flag
// - No key by sequence end: run normally
// - Strobe, data in, clock in, data out
// - Command is 32 bits, bit 31 first
// - Previous response shifts out meanwhile
// - First response after entry is undefined
// - Output driven low by second edge
// - Write done sets ready, output high
// - Read byte lands in low eight bits
// - Addresses match normal operation addresses
// - Only power-down leaves programming mode
// - Bit 29 data target, 28 code
// - Bit 24 one reads, zero writes
// - Address echoed, low byte carries data
`timescale 1ns/1ps
`default_nettype none
`include "serial_program_port_params.svh"

module serial_program_port #(
  parameter int RESET_CYCLES = `RESET_SEQ_NS / `MCLK_NS
) (
  // Main clock and power-on reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // External reset pin, active low
  input wire logic i_ext_reset_n,
  // Programming pins
  input wire logic i_shift_clock_pin,
  input wire logic i_strobe_pin,
  input wire logic i_cmd_in_pin,
  input wire logic i_prog_guard_pin,
  output logic o_resp_out_pin,
  // EEPROM access
  output serial_program_port_pkg::mem_req_t o_mem,
  output logic o_mem_req,
  input wire logic i_mem_ack,
  input wire logic [`DATA_W-1:0] i_mem_rdata,
  // Status
  output logic o_prog_mode,
  output logic o_run,
  output logic o_ready
);
  import serial_program_port_pkg::*;

  // ---------------- Link domain (shift clock) ----------------
  logic lrst_m, lrst; // Reset brought onto the shift clock
  logic [`KEY_W-1:0] key_sr; // Last ten bits seen
  logic key_hit; // Key match, level
  logic [`WORD_W-1:0] rx_sr; // Incoming command bits
  logic [`WORD_W-1:0] tx_sr; // Outgoing response bits
  logic tx_bit; // Bit presented to the output path
  logic [`BIT_CNT_W-1:0] bit_cnt; // Bits of this frame
  logic [1:0] low_cnt; // Edges seen with strobe low
  cmd_word_t cmd_link; // Command held for the engine
  logic launch_tog; // Flips once per launched command
  cmd_word_t resp_word; // Response, written by main domain

  // Decoded link conditions
  wire first_bit = (bit_cnt == '0);
  wire launch_edge = !i_strobe_pin && (low_cnt == `LOW_PULSES - 2'h1);

  // Reset synchroniser for the link side
  always_ff @(posedge i_shift_clock_pin) begin
    lrst_m <= i_rst;
    lrst <= lrst_m;
  end

  // Key shifter, every rising edge
  always_ff @(posedge i_shift_clock_pin) begin
    key_sr <= {key_sr[`KEY_W-2:0], i_cmd_in_pin};
    key_hit <= ({key_sr[`KEY_W-2:0], i_cmd_in_pin} == `KEY_VALUE);
  end

  // Command shift in, response shift out
  always_ff @(posedge i_shift_clock_pin) begin
    if (i_strobe_pin) begin
      rx_sr <= {rx_sr[`WORD_W-2:0], i_cmd_in_pin};
      if (first_bit) begin
        // Load response, send its top bit
        tx_bit <= resp_word[`WORD_W-1];
        tx_sr <= {resp_word[`WORD_W-2:0], 1'b0};
      end else begin
        tx_bit <= tx_sr[`WORD_W-1];
        tx_sr <= {tx_sr[`WORD_W-2:0], 1'b0};
      end
    end
  end

  // Frame control and launch event
  always_ff @(posedge i_shift_clock_pin) begin
    if (lrst) begin
      bit_cnt <= '0;
      low_cnt <= '0;
      launch_tog <= 1'b0;
      cmd_link <= '0;
    end else if (i_strobe_pin) begin
      // Counting bits of the frame
      bit_cnt <= bit_cnt + `BIT_CNT_W'(1);
      low_cnt <= '0;
    end else begin
      bit_cnt <= '0;
      if (low_cnt != `LOW_PULSES)
        low_cnt <= low_cnt + 2'h1;
      if (launch_edge) begin
        // Second low edge launches the command
        cmd_link <= rx_sr;
        launch_tog <= !launch_tog;
      end
    end
  end

  // ---------------- Main domain ----------------
  logic ext_m, ext_s; // External reset pin sync
  logic grd_m, grd_s; // Guard pin sync
  logic stb_m, stb_s, stb_q; // Strobe sync plus edge stage
  logic txb_m, txb_s; // Response bit sync
  logic key_m, key_s; // Key match sync
  logic tog_m, tog_s, tog_q; // Launch toggle sync plus edge stage
  logic [`SEQ_CNT_W-1:0] seq_cnt; // Reset sequence timer
  logic seq_active; // Reset sequence running
  logic prog_flag; // Programming mode
  eng_state_t state; // Memory engine state
  cmd_word_t cmd_m; // Command as seen by the engine

  // Events taken from synchronised stages only
  wire stb_fall = stb_q && !stb_s;
  wire launch = tog_s ^ tog_q;
  wire seq_done = (seq_cnt == `SEQ_CNT_W'(RESET_CYCLES));
  wire mem_done = (state == ST_WAIT) && i_mem_ack;
  wire hold_low = (state != ST_IDLE);
  wire next_resp = !prog_flag ? 1'b1 :
                   hold_low ? 1'b0 :
                   stb_s ? txb_s : 1'b1;

  // Synchronisers for pins and link signals
  always_ff @(posedge i_mclk) begin
    ext_m <= i_ext_reset_n;
    ext_s <= ext_m;
    grd_m <= i_prog_guard_pin;
    grd_s <= grd_m;
    stb_m <= i_strobe_pin;
    stb_s <= stb_m;
    stb_q <= stb_s;
    txb_m <= tx_bit;
    txb_s <= txb_m;
    key_m <= key_hit;
    key_s <= key_m;
    tog_m <= launch_tog;
    tog_s <= tog_m;
    tog_q <= tog_s;
  end

  // Reset sequence, restarted while the pin is held low
  always_ff @(posedge i_mclk) begin
    if (i_rst || !ext_s) begin
      seq_cnt <= '0;
      seq_active <= 1'b1;
    end else if (seq_active) begin
      if (seq_done)
        seq_active <= 1'b0;
      else
        seq_cnt <= seq_cnt + `SEQ_CNT_W'(1);
    end
  end

  // Programming mode flag and run status
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prog_flag <= 1'b0;
      o_prog_mode <= 1'b0;
      o_run <= 1'b0;
    end else begin
      if (seq_active && key_s)
        prog_flag <= 1'b1;
      o_prog_mode <= prog_flag && !seq_active;
      o_run <= !seq_active && !prog_flag;
    end
  end

  // Memory engine
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cmd_m <= '0;
      resp_word <= '0;
      o_mem <= '0;
      o_mem_req <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Strobe fall starts the busy phase
          if (stb_fall && prog_flag && grd_s)
            state <= ST_ARMED;
        end
        ST_ARMED: begin
          if (launch) begin
            cmd_m <= cmd_link;
            o_mem.data_sel <= cmd_link.data_sel;
            o_mem.code_sel <= cmd_link.code_sel;
            o_mem.write <= !cmd_link.read;
            o_mem.addr <= cmd_link.addr;
            o_mem.wdata <= cmd_link.data;
            o_mem_req <= 1'b1;
            o_ready <= 1'b0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            resp_word <= cmd_m;
            if (cmd_m.read)
              resp_word.data <= i_mem_rdata;
            o_ready <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Serial output, busy low until the engine is idle
  always_ff @(posedge i_mclk) begin
    if (i_rst)
      o_resp_out_pin <= 1'b1;
    else
      o_resp_out_pin <= next_resp;
  end

  // ---------------- Checks ----------------
  key_latch_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(prog_flag) |-> $past(seq_active) && $past(key_s))
    else $error("program mode set without key during reset");

  prog_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    prog_flag |=> prog_flag)
    else $error("program mode left without power-down");

  normal_run_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $fell(seq_active) && !prog_flag && !key_s |=> o_run)
    else $error("normal run missing after reset sequence");

  busy_low_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    stb_fall && prog_flag && grd_s && (state == ST_IDLE) |-> ##2 !o_resp_out_pin)
    else $error("output not driven low after strobe fall");

  ready_done_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    mem_done && !stb_s && !stb_m |=> o_ready ##1 o_resp_out_pin)
    else $error("completion not signalled");

  read_load_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    mem_done && cmd_m.read |=> resp_word.data == $past(i_mem_rdata))
    else $error("read byte not loaded");

  addr_echo_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    mem_done |=> resp_word.addr == o_mem.addr)
    else $error("address not echoed");

  dir_sel_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_mem_req) |-> o_mem.write == !cmd_m.read)
    else $error("direction bit not obeyed");

  rx_order_a: assert property (@(posedge i_shift_clock_pin) disable iff (lrst)
    i_strobe_pin |=> rx_sr[0] == $past(i_cmd_in_pin))
    else $error("command bit not shifted in");

  tx_order_a: assert property (@(posedge i_shift_clock_pin) disable iff (lrst)
    i_strobe_pin && !first_bit |=> tx_bit == $past(tx_sr[`WORD_W-1]))
    else $error("response bit order broken");

  entry_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    $rose(o_prog_mode));

  write_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    mem_done && !cmd_m.read);

  read_c: cover property (@(posedge i_mclk) disable iff (i_rst)
    mem_done && cmd_m.read);

endmodule : serial_program_port

`default_nettype wire

/* File: verilog/serial_program_port_params.svh */
/*
  Constants for the serial programming port: entry key, word layout
  widths and reset sequence timing.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef SERIAL_PROGRAM_PORT_PARAMS_SVH
`define SERIAL_PROGRAM_PORT_PARAMS_SVH

// Entry key and its length
`define KEY_W 10
`define KEY_VALUE 10'h34b

// Command and response word
`define WORD_W 32
`define ADDR_W 11
`define DATA_W 8
`define BIT_CNT_W 5
`define LAST_BIT 5'h1f

// Shift clock pulses in the strobe-low phase
`define LOW_PULSES 2'h2

// Main clock period and internal reset sequence length
`define MCLK_NS 100
`define RESET_SEQ_NS 1000000
`define SEQ_CNT_W 24

`endif

/* File: verilog/serial_program_port_pkg.sv */
/*
  Types of the serial programming port: command word layout, memory
  request carrier and engine states.
  Assumes the params header sits in the include path.
*/
`include "serial_program_port_params.svh"

package serial_program_port_pkg;

  // Command and response word, bit 31 first on the wire
  typedef struct packed {
    logic [1:0] rsv_hi;
    logic data_sel;
    logic code_sel;
    logic [2:0] rsv_mid;
    logic read;
    logic [4:0] rsv_lo;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } cmd_word_t;

  // Request to the EEPROM arrays
  typedef struct packed {
    logic data_sel;
    logic code_sel;
    logic write;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
  } mem_req_t;

  // Memory engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_WAIT
  } eng_state_t;

endpackage : serial_program_port_pkg
